// >>> rtl/asp_baud.sv
// sixteen-times bit-rate tick selection for both directions
`timescale 1ns/1ns
`default_nettype none
module asp_baud (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [1:0] mode_i,   // mode-select bits
   input wire logic doubler_i,      // baud_doubler
   input wire logic t1_ovf_i,       // timer 1 overflow pulse
   input wire logic t2_ovf_i,       // timer 2 overflow pulse
   input wire logic tx_t2_i,        // tx clock from timer 2
   input wire logic rx_t2_i,        // rx clock from timer 2
   output logic tx_tick_o,          // 16x tick for transmitter
   output logic rx_tick_o,          // 16x tick for receiver
   output logic shift_tick_o        // mode 0 fixed bit tick
);
   // whole state of the selector
   typedef struct packed {
      logic [1:0] pre;   // mode 2 prescaler
      logic half;        // timer 1 overflow halver
      logic [3:0] div12; // mode 0 divider
   } asp_baud_s;
   asp_baud_s st_r;
   asp_baud_s st_nxt;
   logic m2_tick;
   logic t1_tick;

   // tick decode from the current state
   always_comb
   begin
      m2_tick = doubler_i ? st_r.pre[0] : (st_r.pre == asp_pkg::PRE_M2_LAST);
      t1_tick = t1_ovf_i & (doubler_i | st_r.half);
      tx_tick_o = 1'b0;
      rx_tick_o = 1'b0;
      shift_tick_o = 1'b0;
      unique case (mode_i)
         asp_pkg::MODE_SHIFT: shift_tick_o = ce_i & (st_r.div12 == asp_pkg::DIV_M0_LAST);
         asp_pkg::MODE_9FIX:
         begin
            tx_tick_o = ce_i & m2_tick;
            rx_tick_o = ce_i & m2_tick;
         end
         asp_pkg::MODE_8BIT, asp_pkg::MODE_9VAR:
         begin
            tx_tick_o = ce_i & (tx_t2_i ? t2_ovf_i : t1_tick);
            rx_tick_o = ce_i & (rx_t2_i ? t2_ovf_i : t1_tick);
         end
      endcase
   end

   // next state of the dividers
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.pre = st_r.pre + 2'h1;
      if (t1_ovf_i)
         st_nxt.half = ~st_r.half;
      if (st_r.div12 == asp_pkg::DIV_M0_LAST)
         st_nxt.div12 = 4'h0;
      else
         st_nxt.div12 = st_r.div12 + 4'h1;
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end
endmodule // asp_baud
`default_nettype wire

// >>> rtl/asp_pkg.sv
// constants, register map and state types of the async serial port
package asp_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] OFS_CTRL = 8'h00;   // serial_control
   localparam logic [7:0] OFS_BUF = 8'h01;    // serial_buffer
   localparam logic [7:0] OFS_PWR = 8'h02;    // power_control
   localparam logic [7:0] OFS_T2CTL = 8'h03;  // timer2_control
   localparam logic [7:0] OFS_RLD_LO = 8'h04; // timer2_reload_low
   localparam logic [7:0] OFS_RLD_HI = 8'h05; // timer2_reload_high
   localparam logic [7:0] OFS_STAT = 8'h06;   // engine busy status
   // serial_control bit positions
   localparam int CTRL_RI = 0;  // rx_done_flag
   localparam int CTRL_TI = 1;  // tx_done_flag
   localparam int CTRL_RB8 = 2; // rx_ninth_bit
   localparam int CTRL_TB8 = 3; // tx_ninth_bit
   localparam int CTRL_REN = 4; // receive enable
   localparam int CTRL_SM2 = 5; // multiproc_filter
   localparam int CTRL_SML = 6; // mode_select_low
   localparam int CTRL_SMH = 7; // mode_select_high
   // power_control and timer2_control bit positions
   localparam int PWR_DBL = 7;  // baud_doubler
   localparam int T2_RUN = 2;   // timer 2 run
   localparam int T2_TX_CLOCK_FROM_TIMER2 = 4;  // tx_clock_from_timer2
   localparam int T2_RCLK = 5;  // rx clock from timer 2
   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] T2CTL_RST = 8'h00;
   localparam logic [15:0] RLD_RST = 16'h0000;
   localparam logic [8:0] RX_PRELOAD = 9'h1ff;
   // mode encodings of the two mode-select bits
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_8BIT = 2'h1;
   localparam logic [1:0] MODE_9FIX = 2'h2;
   localparam logic [1:0] MODE_9VAR = 2'h3;
   // bit-time counter states (sixteen per bit)
   localparam logic [3:0] SMP_FIRST = 4'h6; // 7th counter state
   localparam logic [3:0] SMP_LAST = 4'h8;  // 9th counter state
   localparam logic [3:0] CNT_ROLL = 4'hf;
   // fixed prescalers
   localparam logic [1:0] PRE_M2_LAST = 2'h3;   // mode 2: clk/4 ticks = clk/64 bits
   localparam logic [3:0] DIV_M0_LAST = 4'hb;   // mode 0: clk/12
   localparam logic [15:0] T2_TOP = 16'hffff;
   // stop-bit test pattern in tx shift register upper bits
   localparam logic [7:0] TX_LAST_PAT = 8'h01;
   // receive and transmit states, gray coded along the path
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_BUSY = 2'b01, RX_TAIL = 2'b11} asp_rx_e;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b11} asp_tx_e;
endpackage

// >>> rtl/asp_t2_gen.sv
// timer 2 in bit-rate generator mode: auto-reloading 16-bit count at clk/2
`timescale 1ns/1ns
`default_nettype none
module asp_t2_gen (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic run_i,            // generator enabled
   input wire logic [15:0] reload_i,  // software preset reload pair
   output logic ovf_o                 // one-cycle overflow pulse
);
   // whole state of the generator
   typedef struct packed {
      logic phase;       // halves the clock
      logic [15:0] cnt;  // running count
   } asp_t2_s;
   asp_t2_s st_r;
   asp_t2_s st_nxt;

   // overflow when the count wraps on a counting phase
   assign ovf_o = ce_i & run_i & st_r.phase & (st_r.cnt == asp_pkg::T2_TOP);

   // next state: count every other cycle, reload on overflow
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.phase = ~st_r.phase;
      // a stopped timer waits at the reload value, so the first period is full length
      if (!run_i)
         st_nxt.cnt = reload_i;
      else if (st_r.phase)
      begin
         if (st_r.cnt == asp_pkg::T2_TOP)
            st_nxt.cnt = reload_i;
         else
            st_nxt.cnt = st_r.cnt + 16'h0001;
      end
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end
endmodule // asp_t2_gen
`default_nettype wire

// >>> rtl/asp_uart.sv
// async serial port top: registers, receiver (modes 1-3), transmitter (modes 2-3)
// Operation
// - mode 1 rx starts on falling edge, 16x
// - start edge preloads ones, restarts bit counter
// - sample states 7,8,9; take majority
// - high first bit is false start, rehunt
// - shift in right; start at left, final shift
// - mode 1 final: load if filter/stop ok, flag clear
// - mode 1 rehunt right after final shift
// - frame: start, 8 data lsb first, ninth, stop
// - tx sends software ninth; rx stores ninth
// - mode 2 rate clk times doubler over 64
// - mode 3 rate from timer 1 or 2 per direction
// - buffer write loads, starts after counter rollover
// - start bit, data one bit later, then shifts
// - first shift inserts stop; finish at 11th rollover
// - modes 2/3 load if filter/ninth ok, flag clear
// - modes 2/3 rehunt one bit after final shift
// - mode 0 rate is clk over twelve
// - timer 1 rate: doubler times overflow over 32
// - timer 2 rate: overflow rate over sixteen
// - timer 2 reloads on overflow, clk/2 count
// - buffer read gives rx, write starts tx in modes 2/3
// - mode bits: 00 shift,01 8bit,10/11 9bit
// - reception starts only while receive enable set
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module asp_uart (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,            // freezes all state while low
   input wire logic [7:0] addr_i,    // register address
   input wire logic [7:0] wdata_i,   // register write data
   input wire logic wr_i,            // write strobe
   input wire logic rd_i,            // read strobe
   output logic [7:0] rdata_o,       // read data, cycle after rd_i
   input wire logic rxd_i,           // serial input pin
   output logic txd_o,               // serial output pin
   input wire logic timer1_ovf_i,    // timer 1 overflow pulse, same clock
   output logic mode0_tick_o         // mode 0 fixed-rate bit tick
);
   // whole state of the port
   typedef struct packed {
      logic [1:0] rxd_sync;      // pin synchroniser
      logic rxd_prev;            // last sampled level for edge hunt
      asp_pkg::asp_rx_e rx_st;   // receiver state
      logic [3:0] rx_cnt;        // rx bit-time counter
      logic [1:0] rx_smp;        // first two majority samples
      logic [8:0] rx_shift;      // rx input shift register
      asp_pkg::asp_tx_e tx_st;   // transmitter state
      logic [3:0] tx_div;        // tx divide-by-16 counter
      logic tx_pend;             // transmission requested
      logic tx_shifted;          // first shift already done
      logic [8:0] tx_shift;      // tx shift register
      logic txd;                 // registered serial output
      logic [7:0] ctrl;          // serial_control
      logic [7:0] rx_buf;        // receive half of serial_buffer
      logic doubler;             // baud_doubler
      logic [7:0] t2ctl;         // timer2_control
      logic [15:0] reload;       // timer2 reload pair
      logic [7:0] rdata;         // read data register
   } asp_state_s;

   asp_state_s st_r;
   asp_state_s st_nxt;
   logic tx_tick;        // 16x tick, transmit side
   logic rx_tick;        // 16x tick, receive side
   logic t2_ovf;         // timer 2 overflow pulse
   logic [1:0] mode;     // mode-select pair
   logic rxd_s;          // synchronised serial input
   logic rx_bit;         // majority value of current bit
   logic rx_ok;          // final-shift acceptance
   logic set_ri;         // hardware sets rx_done_flag
   logic set_ti;         // hardware sets tx_done_flag
   logic load_rb8;       // hardware loads rx_ninth_bit
   logic rb8_val;        // value for rx_ninth_bit
   logic buf_wr;         // write to serial_buffer
   logic nine_bit;       // modes 2 or 3

   // majority of three samples
   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   // bit order reversal: first received bit lands lowest
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
         rev8[i] = v[7 - i];
   endfunction

   assign mode = {st_r.ctrl[asp_pkg::CTRL_SMH], st_r.ctrl[asp_pkg::CTRL_SML]};
   assign nine_bit = mode[1];
   assign rxd_s = st_r.rxd_sync[1];
   assign txd_o = st_r.txd;
   assign rdata_o = st_r.rdata;

   // bit-rate tick selection
   asp_baud u_baud (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .mode_i(mode),
      .doubler_i(st_r.doubler),
      .t1_ovf_i(timer1_ovf_i),
      .t2_ovf_i(t2_ovf),
      .tx_t2_i(st_r.t2ctl[asp_pkg::T2_TX_CLOCK_FROM_TIMER2]),
      .rx_t2_i(st_r.t2ctl[asp_pkg::T2_RCLK]),
      .tx_tick_o(tx_tick),
      .rx_tick_o(rx_tick),
      .shift_tick_o(mode0_tick_o)
   );

   // timer 2 generator runs when started and picked by either direction
   asp_t2_gen u_t2 (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .run_i(st_r.t2ctl[asp_pkg::T2_RUN]
             & (st_r.t2ctl[asp_pkg::T2_TX_CLOCK_FROM_TIMER2] | st_r.t2ctl[asp_pkg::T2_RCLK])),
      .reload_i(st_r.reload),
      .ovf_o(t2_ovf)
   );

   // receiver, transmitter and register file next state
   always_comb
   begin
      st_nxt = st_r;
      set_ri = 1'b0;
      set_ti = 1'b0;
      load_rb8 = 1'b0;
      rb8_val = 1'b0;
      rx_ok = 1'b0;
      buf_wr = wr_i && (addr_i == asp_pkg::OFS_BUF);
      rx_bit = maj3(st_r.rx_smp[1], st_r.rx_smp[0], rxd_s);

      // pin synchroniser
      st_nxt.rxd_sync = {st_r.rxd_sync[0], rxd_i};

      // receiver on its 16x tick
      if (rx_tick)
      begin
         st_nxt.rxd_prev = rxd_s;
         st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
         if (st_r.rx_cnt >= asp_pkg::SMP_FIRST && st_r.rx_cnt < asp_pkg::SMP_LAST)
            st_nxt.rx_smp = {st_r.rx_smp[0], rxd_s};
         unique case (st_r.rx_st)
            asp_pkg::RX_IDLE:
            begin
               // falling-edge hunt, only while enabled
               if (st_r.ctrl[asp_pkg::CTRL_REN] && st_r.rxd_prev && !rxd_s)
               begin
                  st_nxt.rx_st = asp_pkg::RX_BUSY;
                  st_nxt.rx_shift = asp_pkg::RX_PRELOAD;
                  st_nxt.rx_cnt = 4'h0;
               end
            end
            asp_pkg::RX_BUSY:
            begin
               if (st_r.rx_cnt == asp_pkg::SMP_LAST)
               begin
                  if (st_r.rx_shift == asp_pkg::RX_PRELOAD)
                  begin
                     // start bit time
                     if (rx_bit)
                        st_nxt.rx_st = asp_pkg::RX_IDLE;
                     else
                        st_nxt.rx_shift = {st_r.rx_shift[7:0], rx_bit};
                  end
                  else if (!st_r.rx_shift[8])
                  begin
                     // start bit at the left: final shift
                     st_nxt.rx_shift = {st_r.rx_shift[7:0], rx_bit};
                     rx_ok = (!st_r.ctrl[asp_pkg::CTRL_SM2] || rx_bit)
                             && !st_r.ctrl[asp_pkg::CTRL_RI];
                     if (rx_ok)
                     begin
                        st_nxt.rx_buf = rev8(st_r.rx_shift[7:0]);
                        load_rb8 = 1'b1;
                        rb8_val = rx_bit;
                        set_ri = 1'b1;
                     end
                     if (nine_bit)
                        st_nxt.rx_st = asp_pkg::RX_TAIL;
                     else
                        st_nxt.rx_st = asp_pkg::RX_IDLE;
                  end
                  else
                     st_nxt.rx_shift = {st_r.rx_shift[7:0], rx_bit};
               end
            end
            asp_pkg::RX_TAIL:
            begin
               // stop bit time passes unexamined
               if (st_r.rx_cnt == asp_pkg::SMP_LAST)
                  st_nxt.rx_st = asp_pkg::RX_IDLE;
            end
            default: st_nxt.rx_st = asp_pkg::RX_IDLE;
         endcase
      end

      // buffer write in nine-bit modes loads and requests a send
      if (buf_wr && nine_bit && st_r.tx_st == asp_pkg::TX_IDLE && !st_r.tx_pend)
      begin
         st_nxt.tx_shift = {st_r.ctrl[asp_pkg::CTRL_TB8], wdata_i};
         st_nxt.tx_pend = 1'b1;
      end

      // transmitter steps on divide-by-16 rollovers
      if (tx_tick)
      begin
         st_nxt.tx_div = st_r.tx_div + 4'h1;
         if (st_r.tx_div == asp_pkg::CNT_ROLL)
         begin
            unique case (st_r.tx_st)
               asp_pkg::TX_IDLE:
               begin
                  if (st_r.tx_pend)
                  begin
                     st_nxt.tx_st = asp_pkg::TX_START;
                     st_nxt.tx_pend = 1'b0;
                     st_nxt.tx_shifted = 1'b0;
                     st_nxt.txd = 1'b0;
                  end
               end
               asp_pkg::TX_START:
               begin
                  // output now follows the shift register
                  st_nxt.tx_st = asp_pkg::TX_DATA;
                  st_nxt.txd = st_r.tx_shift[0];
               end
               asp_pkg::TX_DATA:
               begin
                  if (st_r.tx_shifted && st_r.tx_shift[8:1] == asp_pkg::TX_LAST_PAT)
                  begin
                     // ninth bit has been out: last shift, stop bit
                     st_nxt.tx_shift = {1'b0, st_r.tx_shift[8:1]};
                     st_nxt.tx_st = asp_pkg::TX_IDLE;
                     st_nxt.txd = 1'b1;
                     set_ti = 1'b1;
                  end
                  else
                  begin
                     st_nxt.tx_shift = {~st_r.tx_shifted, st_r.tx_shift[8:1]};
                     st_nxt.tx_shifted = 1'b1;
                     st_nxt.txd = st_r.tx_shift[1];
                  end
               end
               default: st_nxt.tx_st = asp_pkg::TX_IDLE;
            endcase
         end
      end

      // register writes
      if (wr_i)
      begin
         unique case (addr_i)
            asp_pkg::OFS_CTRL: st_nxt.ctrl = wdata_i;
            asp_pkg::OFS_PWR: st_nxt.doubler = wdata_i[asp_pkg::PWR_DBL];
            asp_pkg::OFS_T2CTL: st_nxt.t2ctl = wdata_i;
            asp_pkg::OFS_RLD_LO: st_nxt.reload[7:0] = wdata_i;
            asp_pkg::OFS_RLD_HI: st_nxt.reload[15:8] = wdata_i;
            default: ;
         endcase
      end

      // hardware sets win over a software clear in the same cycle
      if (load_rb8)
         st_nxt.ctrl[asp_pkg::CTRL_RB8] = rb8_val;
      if (set_ri)
         st_nxt.ctrl[asp_pkg::CTRL_RI] = 1'b1;
      if (set_ti)
         st_nxt.ctrl[asp_pkg::CTRL_TI] = 1'b1;

      // read data for the cycle after the strobe
      st_nxt.rdata = 8'h00;
      if (rd_i)
      begin
         unique case (addr_i)
            asp_pkg::OFS_CTRL: st_nxt.rdata = st_r.ctrl;
            asp_pkg::OFS_BUF: st_nxt.rdata = st_r.rx_buf;
            asp_pkg::OFS_PWR: st_nxt.rdata = {st_r.doubler, 7'h00};
            asp_pkg::OFS_T2CTL: st_nxt.rdata = st_r.t2ctl;
            asp_pkg::OFS_RLD_LO: st_nxt.rdata = st_r.reload[7:0];
            asp_pkg::OFS_RLD_HI: st_nxt.rdata = st_r.reload[15:8];
            asp_pkg::OFS_STAT:
               st_nxt.rdata = {5'h00, st_r.tx_pend,
                               st_r.rx_st != asp_pkg::RX_IDLE,
                               st_r.tx_st != asp_pkg::TX_IDLE};
            default: st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // state register; synchronous reset, ce_i freezes everything
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         st_r <= '0;
         st_r.rxd_sync <= 2'b11;
         st_r.rxd_prev <= 1'b1;
         st_r.rx_st <= asp_pkg::RX_IDLE;
         st_r.rx_shift <= asp_pkg::RX_PRELOAD;
         st_r.tx_st <= asp_pkg::TX_IDLE;
         st_r.txd <= 1'b1;
         st_r.ctrl <= asp_pkg::CTRL_RST;
         st_r.t2ctl <= asp_pkg::T2CTL_RST;
         st_r.reload <= asp_pkg::RLD_RST;
      end
      else if (ce_i)
         st_r <= st_nxt;
   end
endmodule // asp_uart
`default_nettype wire

// >>> testbench/asp_serial_peer.sv
// remote station: sends frames on the input pin, catches frames from the output pin
`timescale 1ns/1ns
`default_nettype none
module asp_serial_peer (
   input wire logic clk_i,
   input wire logic [7:0] bit_len_i, // clocks per bit
   input wire logic txd_i,
   output logic rxd_o
);
   logic [10:0] got; // last caught frame, first bit at 0
   int i;
   initial rxd_o = 1'b1; // line pulled high
   // sample each bit at its centre
   always
   begin
      @(negedge txd_i);
      repeat (bit_len_i / 2) @(posedge clk_i);
      for (i = 0; i < 11; i++)
      begin
         if (i > 0)
            repeat (bit_len_i) @(posedge clk_i);
         got[i] = txd_i;
      end
   end
   // eleven bits, first bit first
   task automatic send(input logic [10:0] f);
      int k;
      for (k = 0; k < 11; k++)
      begin
         @(posedge clk_i);
         rxd_o <= f[k];
         repeat (bit_len_i - 8'd1) @(posedge clk_i);
      end
   endtask
   // short low pulse, then settle
   task automatic glitch();
      @(posedge clk_i);
      rxd_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      rxd_o <= 1'b1;
      repeat (2 * bit_len_i) @(posedge clk_i);
   endtask
endmodule // asp_serial_peer
`default_nettype wire

// >>> testbench/asp_uart_properties.sv
// pin and register-port checks of the async serial port
`timescale 1ns/1ns
`default_nettype none
module asp_uart_properties (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic txd_o,
   input wire logic mode0_tick_o
);
   logic [7:0] ctl_r; // software view of control
   logic dbl_r; // software view of doubler
   logic txd_q; // pin one cycle back
   logic [15:0] run_r; // cycles since pin change
   // shadows follow software writes only
   always_ff @(posedge clk_sys_i)
   begin
      if (!reset_n_i)
      begin
         txd_q <= 1'b1;
         run_r <= 16'h0;
         ctl_r <= 8'h00;
         dbl_r <= 1'b0;
      end
      else
      begin
         txd_q <= txd_o;
         run_r <= (txd_o != txd_q) ? 16'h0 : run_r + 16'h1;
         if (wr_i && ce_i && addr_i == asp_pkg::OFS_CTRL)
            ctl_r <= wdata_i;
         else if (wr_i && ce_i && addr_i == asp_pkg::OFS_PWR)
            dbl_r <= wdata_i[asp_pkg::PWR_DBL];
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   // no tick for eight cycles
   sequence s_quiet;
      (!mode0_tick_o) [*8];
   endsequence
   a_rd_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero");
   a_unmapped_zero: assert property (rd_i && addr_i > asp_pkg::OFS_STAT |=> !rdata_o)
      else $error("unmapped read not zero");
   a_ctrl_back: assert property (rd_i && addr_i == asp_pkg::OFS_CTRL |=>
      rdata_o[7:3] == ctl_r[7:3]) else $error("control readback wrong");
   a_dbl_back: assert property (rd_i && addr_i == asp_pkg::OFS_PWR |=>
      rdata_o[7] == dbl_r) else $error("doubler readback wrong");
   a_idle_high: assert property (!ctl_r[7] |-> txd_o)
      else $error("output left idle level");
   a_bit_len: assert property (ctl_r[7:6] == asp_pkg::MODE_9FIX && $rose(txd_o) |->
      (dbl_r ? run_r[4:0] == 5'h1f : run_r[5:0] == 6'h3f)) else $error("bit length wrong");
   a_low_bound: assert property (ctl_r[7:6] == asp_pkg::MODE_9FIX && !txd_o && !txd_q |->
      run_r < 16'd640) else $error("low run too long");
   a_tick_mode: assert property (mode0_tick_o |-> ctl_r[7:6] == asp_pkg::MODE_SHIFT && ce_i)
      else $error("tick outside mode 0");
   a_tick_space: assert property (mode0_tick_o |=> s_quiet)
      else $error("ticks too close");
endmodule // asp_uart_properties
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench of the async serial port
`timescale 1ns/1ns
`default_nettype none
bind asp_uart asp_uart_properties chk_u (.*);
module tb;
   logic clk_sys_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ce_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic timer1_ovf_i = 1'b0;
   logic [1:0] t1_cnt = 2'h0; // overflow prescale
   logic [7:0] bit_len = 8'd64; // clocks per line bit
   logic [7:0] rdata_o;
   logic txd_o;
   logic rxd_i;
   logic mode0_tick_o;
   int error_cnt = 0;
   int checks = 0;
   int n;
   int c;
   logic [7:0] v;
   logic [7:0] m;
   logic [7:0] d;
   logic t8;
   // per config: mode, doubler, timer 2 control, bit clocks
   logic [7:0] cm [4] = '{8'h80, 8'h80, 8'hc0, 8'hc0};
   logic [7:0] cp [4] = '{8'h00, 8'h80, 8'h80, 8'h00};
   logic [7:0] ct [4] = '{8'h00, 8'h00, 8'h00, 8'h34};
   logic [7:0] cb [4] = '{8'd64, 8'd32, 8'd64, 8'd64};
   asp_uart dut (.*);
   asp_serial_peer peer (.clk_i(clk_sys_i), .bit_len_i(bit_len), .txd_i(txd_o), .rxd_o(rxd_i));
   always #4 clk_sys_i = ~clk_sys_i;
   // auto-reload timer 1 stand-in: overflow every 4 clocks
   always @(posedge clk_sys_i)
   begin
      t1_cnt <= t1_cnt + 2'h1;
      timer1_ovf_i <= (t1_cnt == 2'h3);
   end
   task automatic finish_test();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] dat);
      @(posedge clk_sys_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= dat;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] dat);
      @(posedge clk_sys_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      dat = rdata_o;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(v, exp);
   endtask
   // bounded wait for a control flag
   task automatic poll(input int b);
      v = 8'h00;
      for (n = 0; n < 4000 && v[b] !== 1'b1; n++)
         rd(asp_pkg::OFS_CTRL, v);
      if (v[b] !== 1'b1)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t: flag wait ran out", $time);
         finish_test();
      end
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_sys_i);
      error_cnt++;
      finish_test();
   end
   initial
   begin
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rchk(asp_pkg::OFS_CTRL, asp_pkg::CTRL_RST);
      rchk(8'h07, 8'h00);
      n = 0;
      repeat (120)
      begin
         @(negedge clk_sys_i);
         if (mode0_tick_o === 1'b1)
            n++;
      end
      chk(n, 10);
      wr(asp_pkg::OFS_CTRL, 8'h40);
      wr(asp_pkg::OFS_BUF, 8'h3c);
      rchk(asp_pkg::OFS_STAT, 8'h00);
      wr(asp_pkg::OFS_RLD_LO, 8'hfe);
      wr(asp_pkg::OFS_RLD_HI, 8'hff);
      rchk(asp_pkg::OFS_RLD_HI, 8'hff);
      // transmit then receive in each rate setting
      for (c = 0; c < 4; c++)
      begin
         bit_len <= cb[c];
         t8 = c[0];
         d = 8'ha5 ^ c[7:0];
         m = cm[c] | 8'h10 | {4'h0, t8, 3'h0};
         wr(asp_pkg::OFS_PWR, cp[c]);
         wr(asp_pkg::OFS_T2CTL, ct[c]);
         wr(asp_pkg::OFS_CTRL, m);
         wr(asp_pkg::OFS_BUF, d);
         poll(asp_pkg::CTRL_TI);
         repeat (bit_len) @(posedge clk_sys_i);
         chk(peer.got, {1'b1, t8, d, 1'b0});
         peer.send({1'b1, !t8, ~d, 1'b0});
         rchk(asp_pkg::OFS_CTRL, m | {5'h0, !t8, 2'h3});
         rchk(asp_pkg::OFS_BUF, ~d);
         wr(asp_pkg::OFS_CTRL, m & 8'hf0);
      end
      bit_len <= 8'd64;
      wr(asp_pkg::OFS_PWR, 8'h00);
      wr(asp_pkg::OFS_T2CTL, 8'h00);
      wr(asp_pkg::OFS_CTRL, 8'h90);
      peer.send({2'b11, 8'h11, 1'b0});
      peer.send({2'b11, 8'h22, 1'b0});
      rchk(asp_pkg::OFS_BUF, 8'h11);
      wr(asp_pkg::OFS_CTRL, 8'hb0);
      peer.glitch();
      peer.send({2'b10, 8'h33, 1'b0});
      rchk(asp_pkg::OFS_CTRL, 8'hb0);
      peer.send({2'b11, 8'h44, 1'b0});
      rchk(asp_pkg::OFS_BUF, 8'h44);
      wr(asp_pkg::OFS_CTRL, 8'h80);
      peer.send({2'b11, 8'h55, 1'b0});
      rchk(asp_pkg::OFS_CTRL, 8'h80);
      // mode 1 on doubled timer 1
      wr(asp_pkg::OFS_PWR, 8'h80);
      wr(asp_pkg::OFS_CTRL, 8'h50);
      peer.send({2'b11, 8'h66, 1'b0});
      rchk(asp_pkg::OFS_CTRL, 8'h55);
      rchk(asp_pkg::OFS_BUF, 8'h66);
      wr(asp_pkg::OFS_CTRL, 8'h70);
      peer.send({2'b10, 8'h77, 1'b0});
      rchk(asp_pkg::OFS_CTRL, 8'h70);
      finish_test();
   end
endmodule // tb
`default_nettype wire
